/* hdl/pin_mux_gpio.sv */
// The AXI4-Lite slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
module pin_mux_gpio (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [pin_mux_gpio_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [pin_mux_gpio_pkg::DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [pin_mux_gpio_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [pin_mux_gpio_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [pin_mux_gpio_pkg::N_PINS-1:0] pad_in,
  output logic [pin_mux_gpio_pkg::N_PINS-1:0] pad_out,
  output logic [pin_mux_gpio_pkg::N_PINS-1:0] pad_oe_n,
  output logic [pin_mux_gpio_pkg::N_PINS-1:0] pad_pull_up,
  output logic [pin_mux_gpio_pkg::N_PINS-1:0] pad_pull_down,
  output logic [pin_mux_gpio_pkg::N_PINS-1:0] pad_hyst_en,
  input wire logic [pin_mux_gpio_pkg::N_PINS-1:0] periph_a_out,
  input wire logic [pin_mux_gpio_pkg::N_PINS-1:0] periph_a_oe,
  input wire logic [pin_mux_gpio_pkg::N_PINS-1:0] periph_b_out,
  input wire logic [pin_mux_gpio_pkg::N_PINS-1:0] periph_b_oe,
  output logic [pin_mux_gpio_pkg::N_PINS-1:0] periph_a_in,
  output logic [pin_mux_gpio_pkg::N_PINS-1:0] periph_b_in,
  output logic irq
);
  import pin_mux_gpio_pkg::*;

  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
    input logic [DATA_W-1:0] data, input logic [3:0] strb);
    logic [DATA_W-1:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return (old & ~m) | (data & m);
  endfunction

  function automatic logic is_cfg(input logic [ADDR_W-1:0] a);
    return (a >= CFG_BASE) && (a < CFG_END);
  endfunction

  function automatic logic [SEL_W-1:0] cfg_idx(input logic [ADDR_W-1:0] a);
    return a[SEL_W+1:2];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic aw_have, w_have, bvalid_q, rvalid_q, wr_fire;
  logic [ADDR_W-1:0] aw_addr;
  logic [DATA_W-1:0] w_data, rd_data;
  logic [3:0] w_strb;
  logic rd_ok, wr_ok;
  pin_cfg_t cfg [N_PINS];
  logic [N_PINS-1:0] gpio_dir, gpio_out;
  logic [N_INT-1:0] int_status, int_mask, next_status;
  logic [N_PINT-1:0] pint_mode, pint_high, pint_low, pint_prev, pint_val;
  logic [DATA_W-1:0] sel_reg [2];
  logic [N_PINS-1:0] grp_ena [N_GRP];
  logic [N_PINS-1:0] grp_pol [N_GRP];
  logic [N_GRP-1:0] grp_and, grp_prev, grp_hit;
  logic [N_PINS-1:0] sync1, sync2, filt_q, rep_level, lvl, pin_val;
  logic [FILT_W-1:0] filt_cnt [N_PINS];
  logic [N_PINS-1:0] next_out, next_oe_n, next_pu, next_pd, next_hyst;
  logic [N_PINS-1:0] next_a_in, next_b_in, od_vec;

  // Ready drops with ce so no transfer completes while state is frozen
  assign awready = ce & ~aw_have & ~bvalid_q; // R12
  assign wready = ce & ~w_have & ~bvalid_q;
  assign arready = ce & ~rvalid_q;
  assign bvalid = bvalid_q & ce;
  assign rvalid = rvalid_q & ce;
  assign wr_fire = ce & aw_have & w_have & ~bvalid_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      bvalid_q <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (ce) begin
      if (awvalid && awready) begin
        aw_have <= 1'b1;
        aw_addr <= awaddr;
      end
      if (wvalid && wready) begin
        w_have <= 1'b1;
        w_data <= wdata;
        w_strb <= wstrb;
      end
      if (wr_fire) begin
        aw_have <= 1'b0;
        w_have <= 1'b0;
        bvalid_q <= 1'b1;
        bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else if (ce) begin
      if (arvalid && arready) begin
        rvalid_q <= 1'b1;
        rdata <= rd_data;
        rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_q && rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    rd_ok = 1'b1;
    rd_data = '0;
    if (is_cfg(araddr)) begin
      rd_data = DATA_W'(cfg[cfg_idx(araddr)]);
    end else begin
      case (araddr)
        DIR_OFF: rd_data = DATA_W'(gpio_dir);
        OUT_OFF, SET_OFF, CLR_OFF: rd_data = DATA_W'(gpio_out);
        PIN_OFF: rd_data = DATA_W'(pin_val);
        ISTAT_OFF: rd_data = DATA_W'(int_status);
        IMASK_OFF: rd_data = DATA_W'(int_mask);
        PMODE_OFF: rd_data = DATA_W'(pint_mode);
        PHIGH_OFF: rd_data = DATA_W'(pint_high);
        PLOW_OFF: rd_data = DATA_W'(pint_low);
        PSEL0_OFF: rd_data = sel_reg[0];
        PSEL1_OFF: rd_data = sel_reg[1];
        G0ENA_OFF: rd_data = DATA_W'(grp_ena[0]);
        G0POL_OFF: rd_data = DATA_W'(grp_pol[0]);
        G1ENA_OFF: rd_data = DATA_W'(grp_ena[1]);
        G1POL_OFF: rd_data = DATA_W'(grp_pol[1]);
        GCTRL_OFF: rd_data = DATA_W'(grp_and);
        default: rd_ok = 1'b0;
      endcase
    end
  end

  always_comb begin
    case (aw_addr)
      DIR_OFF, OUT_OFF, SET_OFF, CLR_OFF, ISTAT_OFF, IMASK_OFF, PMODE_OFF,
      PHIGH_OFF, PLOW_OFF, PSEL0_OFF, PSEL1_OFF, G0ENA_OFF, G0POL_OFF,
      G1ENA_OFF, G1POL_OFF, GCTRL_OFF: wr_ok = 1'b1;
      default: wr_ok = is_cfg(aw_addr);
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < N_PINS; i++) begin
        cfg[i] <= CFG_RESET; // R16 R6
      end
    end else if (ce && wr_fire && is_cfg(aw_addr)) begin
      // Only the low byte of the word carries pin settings
      cfg[cfg_idx(aw_addr)] <= pin_cfg_t'(CFG_W'(merge(
        DATA_W'(cfg[cfg_idx(aw_addr)]), w_data, w_strb))); // R1 R4 R8
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gpio_dir <= '0; // R16
      gpio_out <= '0;
    end else if (ce && wr_fire) begin
      case (aw_addr)
        DIR_OFF: gpio_dir <= N_PINS'(merge(DATA_W'(gpio_dir), w_data,
          w_strb)); // R9
        OUT_OFF: gpio_out <= N_PINS'(merge(DATA_W'(gpio_out), w_data,
          w_strb)); // R11
        SET_OFF: gpio_out <= gpio_out | N_PINS'(merge('0, w_data,
          w_strb)); // R10 R18
        CLR_OFF: gpio_out <= gpio_out & ~N_PINS'(merge('0, w_data,
          w_strb)); // R10 R18
        default: ;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_mask <= '0;
      pint_mode <= '0;
      pint_high <= '0;
      pint_low <= '0;
      sel_reg[0] <= '0;
      sel_reg[1] <= '0;
      grp_ena[0] <= '0;
      grp_ena[1] <= '0;
      grp_pol[0] <= '0;
      grp_pol[1] <= '0;
      grp_and <= '0;
    end else if (ce && wr_fire) begin
      case (aw_addr)
        IMASK_OFF: int_mask <= N_INT'(merge(DATA_W'(int_mask), w_data, w_strb));
        PMODE_OFF: pint_mode <= N_PINT'(merge(DATA_W'(pint_mode), w_data,
          w_strb));
        PHIGH_OFF: pint_high <= N_PINT'(merge(DATA_W'(pint_high), w_data,
          w_strb));
        PLOW_OFF: pint_low <= N_PINT'(merge(DATA_W'(pint_low), w_data,
          w_strb));
        PSEL0_OFF: sel_reg[0] <= merge(sel_reg[0], w_data, w_strb) & SEL_MASK;
        PSEL1_OFF: sel_reg[1] <= merge(sel_reg[1], w_data, w_strb) & SEL_MASK;
        G0ENA_OFF: grp_ena[0] <= N_PINS'(merge(DATA_W'(grp_ena[0]), w_data,
          w_strb));
        G0POL_OFF: grp_pol[0] <= N_PINS'(merge(DATA_W'(grp_pol[0]), w_data,
          w_strb));
        G1ENA_OFF: grp_ena[1] <= N_PINS'(merge(DATA_W'(grp_ena[1]), w_data,
          w_strb));
        G1POL_OFF: grp_pol[1] <= N_PINS'(merge(DATA_W'(grp_pol[1]), w_data,
          w_strb));
        GCTRL_OFF: grp_and <= N_GRP'(merge(DATA_W'(grp_and), w_data, w_strb));
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pads are asynchronous, so two flops come before any input logic
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1 <= '1;
      sync2 <= '1;
      rep_level <= '1;
      filt_q <= '1;
      for (int i = 0; i < N_PINS; i++) begin
        filt_cnt[i] <= '0;
      end
    end else if (ce) begin
      sync1 <= pad_in;
      sync2 <= sync1;
      rep_level <= lvl; // R17
      for (int i = 0; i < N_PINS; i++) begin
        if (sync2[i] == filt_q[i]) begin
          filt_cnt[i] <= '0;
        end else if (filt_cnt[i] >= FILTER_CYCLES) begin
          filt_q[i] <= sync2[i]; // R6
          filt_cnt[i] <= '0;
        end else begin
          filt_cnt[i] <= filt_cnt[i] + 1'b1;
        end
      end
    end
  end

  // The filter adds latency, which is why it is opt-in per pin
  always_comb begin
    for (int i = 0; i < N_PINS; i++) begin
      lvl[i] = (cfg[i].filter_en && FILTER_CAPABLE[i]) ? filt_q[i]
        : sync2[i]; // R6
      pin_val[i] = lvl[i] ^ cfg[i].invert; // R7
      od_vec[i] = cfg[i].open_drain;
    end
  end

  always_comb begin
    for (int i = 0; i < N_PINS; i++) begin
      next_out[i] = 1'b0;
      next_oe_n[i] = 1'b1;
      case (cfg[i].func) // R1 R9
        FUNC_GPIO: begin
          next_out[i] = gpio_out[i];
          next_oe_n[i] = ~gpio_dir[i];
        end
        FUNC_PERIPH_A: begin
          next_out[i] = periph_a_out[i];
          next_oe_n[i] = ~periph_a_oe[i];
        end
        FUNC_PERIPH_B: begin
          next_out[i] = periph_b_out[i];
          next_oe_n[i] = ~periph_b_oe[i];
        end
        default: ;
      endcase
      if (cfg[i].open_drain && next_out[i]) begin
        next_oe_n[i] = 1'b1; // R5
      end
      if (cfg[i].open_drain) begin
        next_out[i] = 1'b0; // R5
      end
      // A peripheral not routed here only ever sees a low input
      next_a_in[i] = (cfg[i].func == FUNC_PERIPH_A) & pin_val[i]; // R3
      next_b_in[i] = (cfg[i].func == FUNC_PERIPH_B) & pin_val[i]; // R3
      next_pu[i] = (cfg[i].pull == PULL_UP) ||
        (cfg[i].pull == PULL_REPEAT && rep_level[i]); // R4 R17
      next_pd[i] = (cfg[i].pull == PULL_DOWN) ||
        (cfg[i].pull == PULL_REPEAT && !rep_level[i]); // R4 R17
      next_hyst[i] = cfg[i].hyst_en; // R8
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pad_out <= '0;
      pad_oe_n <= '1; // R16
      pad_pull_up <= '1; // R16
      pad_pull_down <= '0;
      pad_hyst_en <= '0;
      periph_a_in <= '0;
      periph_b_in <= '0;
    end else if (ce) begin
      pad_out <= next_out;
      pad_oe_n <= next_oe_n;
      pad_pull_up <= next_pu;
      pad_pull_down <= next_pd;
      pad_hyst_en <= next_hyst;
      periph_a_in <= next_a_in;
      periph_b_in <= next_b_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [SEL_W-1:0] p;
    logic [N_PINS-1:0] match;
    p = '0;
    match = '0;
    for (int c = 0; c < N_PINT; c++) begin
      p = sel_reg[c / SEL_PER_REG][(c % SEL_PER_REG) * SEL_STRIDE +: SEL_W];
      pint_val[c] = (p < N_PINS) ? pin_val[p] : 1'b0; // R14
      next_status[c] = pint_mode[c]
        ? ((pint_high[c] & pint_val[c]) | (pint_low[c] & ~pint_val[c]))
        : ((pint_high[c] & pint_val[c] & ~pint_prev[c]) |
           (pint_low[c] & ~pint_val[c] & pint_prev[c])); // R13
    end
    for (int g = 0; g < N_GRP; g++) begin
      match = ~(pin_val ^ grp_pol[g]) & grp_ena[g];
      grp_hit[g] = grp_and[g] ? ((match == grp_ena[g]) && (|grp_ena[g]))
        : (|match); // R15
      next_status[N_PINT + g] = grp_hit[g] & ~grp_prev[g]; // R15
    end
  end

  // A new event outranks a same-cycle write-one-to-clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_status <= '0;
      pint_prev <= '0;
      grp_prev <= '0;
    end else if (ce) begin
      pint_prev <= pint_val;
      grp_prev <= grp_hit;
      if (wr_fire && aw_addr == ISTAT_OFF) begin
        int_status <= (int_status & ~N_INT'(merge('0, w_data, w_strb)))
          | next_status;
      end else begin
        int_status <= int_status | next_status;
      end
    end
  end

  assign irq = |(int_status & int_mask);

  ////////////////////////////////////////////////////////////////////////////
  a_set_bits: assert property (@(posedge aclk) disable iff (!aresetn) // R10
    (wr_fire && aw_addr == SET_OFF && w_strb == 4'hF) |=>
    gpio_out == ($past(gpio_out) | $past(w_data[N_PINS-1:0])))
    else $error("set write did not or bits into output");
  a_clr_bits: assert property (@(posedge aclk) disable iff (!aresetn) // R18
    (wr_fire && aw_addr == CLR_OFF && w_strb == 4'hF) |=>
    gpio_out == ($past(gpio_out) & ~$past(w_data[N_PINS-1:0])))
    else $error("clear write did not clear only one bits");
  a_out_whole: assert property (@(posedge aclk) disable iff (!aresetn) // R11
    (wr_fire && aw_addr == OUT_OFF && w_strb == 4'hF) |=>
    gpio_out == $past(w_data[N_PINS-1:0]))
    else $error("whole port write not applied");
  a_reset_pull: assert property (@(posedge aclk) // R16
    !aresetn |=> (pad_pull_up == '1 && pad_oe_n == '1 && gpio_dir == '0))
    else $error("pins not inputs with pull-up after reset");
  a_filter_off: assert property (@(posedge aclk) // R6
    !aresetn |=> cfg[11].filter_en == 1'b0)
    else $error("glitch filter enabled after reset");
  a_od_low_only: assert property (@(posedge aclk) disable iff (!aresetn) // R5
    ce |=> (~pad_oe_n & $past(od_vec) & pad_out) == '0)
    else $error("open-drain pin driven high");
  a_pin_edge: assert property (@(posedge aclk) disable iff (!aresetn) // R13
    (ce && !pint_mode[0] && pint_high[0] && pint_val[0] && !pint_prev[0])
    |=> int_status[0])
    else $error("rising edge did not set pin interrupt");
  a_group_hit: assert property (@(posedge aclk) disable iff (!aresetn) // R15
    (ce && grp_hit[0] && !grp_prev[0]) |=> int_status[N_PINT])
    else $error("group pattern did not set group interrupt");
  a_gpio_drive: assert property (@(posedge aclk) disable iff (!aresetn) // R9
    (ce && cfg[0].func == FUNC_GPIO && !cfg[0].open_drain) |=>
    (pad_oe_n[0] == !$past(gpio_dir[0]) && pad_out[0] == $past(gpio_out[0])))
    else $error("gpio pin not driven from port registers");
endmodule

/* hdl/pin_mux_gpio_pkg.sv */
// Function
// R1 - Each pin has a multiplexer choosing one peripheral function or the GPIO port.
// R2 - Software routes a peripheral to its pins before enabling it or its interrupts.
// R3 - An enabled peripheral not routed to any pin behaves undefined.
// R4 - Each pin selects pull-up, pull-down or repeater mode, applied to its pad.
// R5 - Pseudo open-drain drives only low and releases the pin otherwise.
// R6 - Short glitch filter only on port bits 11-16, 22, 23; off after reset.
// R7 - Input inversion delivers the complement of the pin level inward.
// R8 - Each pin has a software-changeable input hysteresis enable.
// R9 - Unrouted pins belong to GPIO; direction changeable at any time.
// R10 - One write sets several output bits, or clears several, leaving others.
// R11 - A full-width write replaces every output bit of the port at once.
// R12 - Port registers sit directly on a dedicated fast bus slave.
// R13 - Any pin interrupts on level, rising edge, falling edge or both edges.
// R14 - Up to eight chosen pins each get their own configured interrupt.
// R15 - Two group units each raise one interrupt from a pattern over chosen pins.
// R16 - After reset GPIO pins are inputs with pull-up enabled.
// R17 - Repeater mode pulls weakly toward the last level seen on the pin.
// R18 - In set and clear writes a one acts on its bit, a zero does nothing.
package pin_mux_gpio_pkg;
  localparam int N_PINS = 24;
  localparam int SEL_W = 5;
  localparam int N_PINT = 8;
  localparam int N_GRP = 2;
  localparam int N_INT = N_PINT + N_GRP;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int SEL_STRIDE = 8;
  localparam int SEL_PER_REG = 4;
  localparam int FILT_W = 3;

  typedef enum logic [1:0] {FUNC_GPIO, FUNC_PERIPH_A, FUNC_PERIPH_B,
    FUNC_NONE} func_t;
  typedef enum logic [1:0] {PULL_NONE, PULL_DOWN, PULL_UP,
    PULL_REPEAT} pull_t;
  typedef struct packed {
    logic open_drain;
    logic filter_en;
    logic invert;
    logic hyst_en;
    pull_t pull;
    func_t func;
  } pin_cfg_t;
  localparam int CFG_W = $bits(pin_cfg_t);
  localparam pin_cfg_t CFG_RESET = '{open_drain: 1'b0, filter_en: 1'b0,
    invert: 1'b0, hyst_en: 1'b0, pull: PULL_UP, func: FUNC_GPIO};

  localparam logic [N_PINS-1:0] FILTER_CAPABLE = 24'hC1F800;
  localparam logic [DATA_W-1:0] SEL_MASK = 32'h1F1F1F1F;

  localparam logic [ADDR_W-1:0] CFG_BASE = 12'h000;
  localparam logic [ADDR_W-1:0] CFG_END = 12'h060;
  localparam logic [ADDR_W-1:0] DIR_OFF = 12'h100;
  localparam logic [ADDR_W-1:0] OUT_OFF = 12'h104;
  localparam logic [ADDR_W-1:0] SET_OFF = 12'h108;
  localparam logic [ADDR_W-1:0] CLR_OFF = 12'h10C;
  localparam logic [ADDR_W-1:0] PIN_OFF = 12'h110;
  localparam logic [ADDR_W-1:0] ISTAT_OFF = 12'h114;
  localparam logic [ADDR_W-1:0] IMASK_OFF = 12'h118;
  localparam logic [ADDR_W-1:0] PMODE_OFF = 12'h11C;
  localparam logic [ADDR_W-1:0] PHIGH_OFF = 12'h120;
  localparam logic [ADDR_W-1:0] PLOW_OFF = 12'h124;
  localparam logic [ADDR_W-1:0] PSEL0_OFF = 12'h128;
  localparam logic [ADDR_W-1:0] PSEL1_OFF = 12'h12C;
  localparam logic [ADDR_W-1:0] G0ENA_OFF = 12'h130;
  localparam logic [ADDR_W-1:0] G0POL_OFF = 12'h134;
  localparam logic [ADDR_W-1:0] G1ENA_OFF = 12'h138;
  localparam logic [ADDR_W-1:0] G1POL_OFF = 12'h13C;
  localparam logic [ADDR_W-1:0] GCTRL_OFF = 12'h140;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam int CLK_PERIOD_NS = 40;
  localparam int FILTER_NS = 10;
  localparam int FILTER_RAW = (FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [FILT_W-1:0] FILTER_CYCLES =
    FILT_W'((FILTER_RAW < 1) ? 1 : FILTER_RAW);
endpackage

/* tb/board_model.sv */
`timescale 1ns/1ns
module board_model
  import pin_mux_gpio_pkg::*;
(
  input wire logic aclk,
  input wire logic [pin_mux_gpio_pkg::N_PINS-1:0] pad_out,
  input wire logic [pin_mux_gpio_pkg::N_PINS-1:0] pad_oe_n,
  input wire logic [pin_mux_gpio_pkg::N_PINS-1:0] pad_pull_up,
  input wire logic [pin_mux_gpio_pkg::N_PINS-1:0] pad_pull_down,
  input wire logic [pin_mux_gpio_pkg::N_PINS-1:0] ext_val,
  input wire logic [pin_mux_gpio_pkg::N_PINS-1:0] ext_en,
  output logic [pin_mux_gpio_pkg::N_PINS-1:0] pad_in
);
  logic [N_PINS-1:0] last = '1;
  always @(posedge aclk) begin
    last <= pad_in;
  end
  // The chip's own driver beats the board drive, as a strong pad would
  always_comb begin
    for (int i = 0; i < N_PINS; i++) begin
      if (!pad_oe_n[i]) pad_in[i] = pad_out[i];
      else if (ext_en[i]) pad_in[i] = ext_val[i];
      else if (pad_pull_up[i]) pad_in[i] = 1'b1;
      else if (pad_pull_down[i]) pad_in[i] = 1'b0;
      // Floating pin toggles so a stale level never looks valid
      else pad_in[i] = ~last[i];
    end
  end
endmodule

/* tb/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
  import pin_mux_gpio_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [DATA_W-1:0] wdata = '0, rdata, d;
  logic [3:0] wstrb = 4'hF;
  logic [1:0] bresp, rresp, resp;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [N_PINS-1:0] pad_in, pad_out, pad_oe_n, pad_pull_up;
  logic [N_PINS-1:0] pad_pull_down, pad_hyst_en, periph_a_in, periph_b_in;
  logic [N_PINS-1:0] periph_a_out = '0, periph_a_oe = '0;
  logic [N_PINS-1:0] periph_b_out = '0, periph_b_oe = '0;
  logic [N_PINS-1:0] ext_val = 24'h5A5A5A, ext_en = 24'hFFFFFF;
  logic [7:0] pcfg [4] = '{8'h04, 8'h00, 8'h18, 8'h0C};
  logic [2:0] pexp [4] = '{3'b010, 3'b000, 3'b101, 3'b010};
  logic [3:0] mexp [4] = '{4'b1000, 4'b0110, 4'b0000, 4'b1000};
  logic [31:0] fexp [3] = '{32'h3, 32'h2, 32'h3};
  logic [2:0] im [4] = '{3'b010, 3'b001, 3'b011, 3'b110};
  logic [2:0] iexp [4] = '{3'b100, 3'b001, 3'b101, 3'b111};
  logic [31:0] gexp [3] = '{32'h0, 32'h100, 32'h300};
  logic [2:0] r;
  int errors = 0, tests_run = 0;
  always #(CLK_PERIOD_NS / 2) aclk = ~aclk;
  pin_mux_gpio uut (.aclk, .aresetn, .ce, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .pad_in,
    .pad_out, .pad_oe_n, .pad_pull_up, .pad_pull_down, .pad_hyst_en,
    .periph_a_out, .periph_a_oe, .periph_b_out, .periph_b_oe,
    .periph_a_in, .periph_b_in, .irq);
  board_model board (.aclk, .pad_out, .pad_oe_n, .pad_pull_up,
    .pad_pull_down, .ext_val, .ext_en, .pad_in);
  ////////////////////////////////////////////////////////////////////////
  task report_and_stop;
    if (errors == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task tmo;
    errors++;
    $display("[FAIL] %0t bus handshake timed out", $time);
    report_and_stop();
  endtask
  // Ready and answer are looked at mid-cycle, so no edge race decides
  task wr(input logic [ADDR_W-1:0] a, input logic [31:0] v);
    logic ah, wh, bh;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 30; n++) begin
      @(negedge aclk);
      ah = awvalid & awready;
      wh = wvalid & wready;
      bh = bvalid;
      resp = bresp;
      @(posedge aclk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
      if (bh) begin
        bready <= 1'b0;
        return;
      end
    end
    tmo();
  endtask
  task rd(input logic [ADDR_W-1:0] a);
    logic ah, rh;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 30; n++) begin
      @(negedge aclk);
      ah = arvalid & arready;
      rh = rvalid;
      d = rdata;
      resp = rresp;
      @(posedge aclk);
      if (ah) arvalid <= 1'b0;
      if (rh) begin
        rready <= 1'b0;
        return;
      end
    end
    tmo();
  endtask
  task st(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask
  task pin(input int i, input logic v);
    @(posedge aclk);
    ext_val[i] <= v;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    st(0);
    chk(pad_oe_n, 24'hFFFFFF);
    chk(pad_pull_up, 24'hFFFFFF);
    chk(pad_pull_down, 24'h000000);
    rd(CFG_BASE);
    chk(d, 32'h08);
    rd(DIR_OFF);
    chk(d, 32'h0);
    rd(PIN_OFF);
    chk(d, 32'h5A5A5A);
    wr(CFG_BASE + 12'h004, 32'h28);
    chk(resp, RESP_OKAY);
    st(3);
    rd(PIN_OFF);
    chk(d, 32'h5A5A58);
    wr(DIR_OFF, 32'hFFFFFF);
    wr(OUT_OFF, 32'hA5A5A5);
    st(1);
    chk(pad_oe_n, 32'h0);
    chk(pad_out, 24'hA5A5A5);
    wr(SET_OFF, 32'h0A);
    wr(CLR_OFF, 32'h81);
    rd(OUT_OFF);
    chk(d, 32'hA5A52E);
    wr(CFG_BASE + 12'h010, 32'h88);
    st(1);
    chk({pad_oe_n[4], pad_out[4]}, 32'h0);
    wr(SET_OFF, 32'h10);
    st(1);
    chk(pad_oe_n[4], 32'h1);
    wr(DIR_OFF, 32'h0);
    for (int i = 0; i < 4; i++) begin
      wr(CFG_BASE + 12'h008, pcfg[i]);
      st(1);
      chk({pad_pull_up[2], pad_pull_down[2], pad_hyst_en[2]}, pexp[i]);
    end
    pin(2, 1'b1);
    st(4);
    chk({pad_pull_up[2], pad_pull_down[2]}, 32'h2);
    wr(CFG_BASE + 12'h018, 32'h09);
    @(posedge aclk);
    periph_a_oe[6] <= 1'b1;
    periph_a_out[6] <= 1'b1;
    periph_b_oe[6] <= 1'b1;
    for (int f = 0; f < 4; f++) begin
      wr(CFG_BASE + 12'h018, 32'h08 | f);
      st(3);
      chk({pad_oe_n[6], pad_out[6] & ~pad_oe_n[6], periph_a_in[6],
        periph_b_in[6]}, mexp[f]);
    end
    ////////////////////////////////////////////////////////////////////////
    @(posedge aclk);
    ext_val <= ext_val & ~24'h000801;
    wr(PSEL0_OFF, 32'h0B);
    wr(PHIGH_OFF, 32'h3);
    st(4);
    wr(ISTAT_OFF, 32'h3FF);
    for (int k = 0; k < 3; k++) begin
      if (k == 1) wr(CFG_BASE, 32'h48);
      if (k == 1) wr(CFG_BASE + 12'h02C, 32'h48);
      @(posedge aclk);
      ext_val <= ext_val | 24'h000801;
      repeat (k == 2 ? 3 : 1) @(posedge aclk);
      ext_val <= ext_val & ~24'h000801;
      st(5);
      rd(ISTAT_OFF);
      chk(d & 32'h3, fexp[k]);
      wr(ISTAT_OFF, 32'h3);
    end
    wr(PSEL0_OFF, 32'h03);
    wr(IMASK_OFF, 32'h1);
    for (int m = 0; m < 4; m++) begin
      wr(PMODE_OFF, im[m][2]);
      wr(PHIGH_OFF, im[m][1]);
      wr(PLOW_OFF, im[m][0]);
      pin(3, 1'b0);
      st(4);
      wr(ISTAT_OFF, 32'h3FF);
      pin(3, 1'b1);
      st(4);
      chk(irq, iexp[m][2]);
      rd(ISTAT_OFF);
      r[2] = d[0];
      wr(ISTAT_OFF, 32'h1);
      rd(ISTAT_OFF);
      r[1] = d[0];
      pin(3, 1'b0);
      st(4);
      rd(ISTAT_OFF);
      r[0] = d[0];
      chk(r, iexp[m]);
    end
    wr(IMASK_OFF, 32'h0);
    st(0);
    chk(irq, 32'h0);
    wr(PHIGH_OFF, 32'h80);
    wr(PMODE_OFF, 32'h0);
    wr(PSEL1_OFF, 32'h03000000);
    wr(ISTAT_OFF, 32'h3FF);
    pin(3, 1'b1);
    st(4);
    rd(ISTAT_OFF);
    chk(d, 32'h80);
    wr(PHIGH_OFF, 32'h0);
    wr(G0ENA_OFF, 32'h18);
    wr(G0POL_OFF, 32'h18);
    wr(G1ENA_OFF, 32'h20);
    wr(G1POL_OFF, 32'h20);
    wr(GCTRL_OFF, 32'h1);
    @(posedge aclk);
    ext_val <= ext_val & ~24'h000038;
    st(4);
    wr(ISTAT_OFF, 32'h3FF);
    for (int j = 0; j < 3; j++) begin
      pin(j + 3, 1'b1);
      st(4);
      rd(ISTAT_OFF);
      chk(d, gexp[j]);
    end
    // Clock enable low must hold every bus ready and answer down
    @(posedge aclk);
    ce <= 1'b0;
    ext_val[5] <= 1'b0;
    st(3);
    chk({awready, wready, arready, bvalid, rvalid}, 5'b00000);
    @(posedge aclk);
    ce <= 1'b1;
    rd(12'h200);
    chk(resp, RESP_SLVERR);
    chk(d, 32'h0);
    wr(12'h200, 32'h1);
    chk(resp, RESP_SLVERR);
    report_and_stop();
  end
endmodule
